// file: src/codec_dsp_serial_port.sv
/*
 * DSP-mode serial port of a telephony codec: bit clock and frame sync
 * generation from the crystal input, data and control frames, control
 * registers, calibration timing, and an AXI4-Lite window for samples.
 * Assumes the crystal, mode pins and incoming serial data are asynchronous
 * to aclk and that aclk is well above five times the crystal rate.
 */
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Function
// RULE_01 - start-up divider assumes the nominal crystal; 12/32 MHz select by field
// RULE_02 - bit clock starts soon after reset release once crystal ticks arrive
// RULE_03 - frame sync starts about 100 us after the bit clock
// RULE_04 - bit and frame rates follow the crystal until the select field changes
// RULE_05 - one 16-bit word each way in the first 16 bit clocks of a frame
// RULE_06 - one-bit high sync pulse one bit before the first data bit
// RULE_07 - words go most significant bit first
// RULE_08 - outputs change on rising bit clock, inputs sampled on falling
// RULE_09 - data frames send 16-bit ADC words, keep 15 upper bits as DAC data
// RULE_10 - incoming data LSB set requests a control frame next
// RULE_11 - control word: rw, six address bits, byte select, eight data bits
// RULE_12 - outgoing control word: zero high byte, read byte or zero low byte
// RULE_13 - idle frames span 512 bits; bits after 16 sent zero, ignored in
// RULE_14 - control frame starts 256 bits after its data frame, own sync
// RULE_15 - frame rate is sample rate when enabled, 8 kHz when powered down
// RULE_16 - enabled frame jitter under 4 percent, exact average rate
// RULE_17 - rate low byte waits in a latch until the high byte is written
// RULE_18 - reading the rate register returns the latch contents
// RULE_19 - extended registers reached only through the bank select field
// RULE_20 - controller sets crystal select before enabling the codec
// RULE_21 - controller leaves rate, source and gain alone during calibration
// RULE_22 - calibration starts on ADC enable or writing one to calibrate bit
// RULE_23 - serial mode pins latched at first reset release after power-up
// RULE_24 - calibrate bit reads one while busy, clears itself when done
module codec_dsp_serial_port #(
    parameter int SYNC_START_CYCLES = codec_dsp_pkg::SYNC_START_CYC,
    parameter int CAL_CYCLES = codec_dsp_pkg::CAL_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic crystal_clock_input,
    input wire logic [1:0] mode_select,
    input wire logic link_rx_data,
    output codec_dsp_pkg::link_out_t link_out,
    output logic crystal_drive_output,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import codec_dsp_pkg::*;

    typedef struct packed {
        logic [2:0] xs;
        logic xl;
        logic [2:0] ds;
        logic dl;
        logic [1:0] m1;
        logic [1:0] m2;
        logic [1:0] m3;
        logic [1:0] ml;
        logic locked;
        logic dsp;
        logic [4:0] seen;
        logic brun;
        logic [3:0] div;
        logic bclk;
        logic [15:0] swait;
        logic srun;
        logic [8:0] idle;
        logic [31:0] acc;
        logic [8:0] since;
        logic pend;
        logic sync;
        logic ctl;
        logic [4:0] txi;
        logic [15:0] txw;
        logic txb;
        logic [4:0] rxc;
        logic [15:0] rxw;
        logic [7:0] pdn;
        logic [7:0] rate_lo;
        logic [15:0] rate;
        logic [15:0] level;
        logic [15:0] cfg1;
        logic [15:0] cfg2;
        logic [15:0] b1_60;
        logic [15:0] b1_64;
        logic [15:0] b2_60;
        logic [15:0] calc;
        logic awg;
        logic wg;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [15:0] adc;
        logic [15:0] dac;
        logic [15:0] fcnt;
    } state_t;

    state_t st;
    state_t next_st;
    logic xtick;
    logic rise;
    logic fall;
    logic due_d;
    logic due_c;
    logic codec_en;
    logic wr_now;
    logic bsel;
    logic cal_start;
    logic [3:0] dn;
    logic [3:0] half;
    logic [3:0] nd;
    logic [31:0] inc;
    logic [31:0] mdl;
    logic [31:0] sum;
    logic [15:0] w16;
    logic [15:0] rbyte;
    logic [6:0] wa;
    logic [7:0] wbyte;

    // crystal divide ratio for one bit clock
    function automatic logic [3:0] div_of(input logic [1:0] code);
        case (code)
            XTAL_12M: div_of = DIV_12M;
            XTAL_32M: div_of = DIV_32M;
            default: div_of = DIV_24M;
        endcase
    endfunction

    // byte merge into a 16-bit register
    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                             input logic [7:0] b);
        put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction

    // control register read map
    function automatic logic [15:0] reg_read(input state_t s, input logic [6:0] a);
        logic [1:0] bank;
        bank = s.cfg1[BNK_LSB+:2];
        reg_read = 16'h0000;
        case (a)
            REG_STAT: reg_read = {s.pdn, 4'h0, ~s.pdn[3:0]};
            REG_RATE: reg_read = {s.rate[15:8], s.rate_lo}; // [RULE_18]
            REG_LEVEL: reg_read = s.level;
            REG_CFG1: reg_read = s.cfg1;
            REG_CFG2: reg_read = s.cfg2;
            REG_BANK_A: begin
                if (bank == BANK_1) begin
                    reg_read = s.b1_60; // [RULE_19]
                end else if (bank == BANK_2) begin
                    reg_read = s.b2_60;
                end
            end
            REG_BANK_B: begin
                if (bank == BANK_1) begin
                    reg_read = s.b1_64;
                end
            end
            REG_VERSION: reg_read = VERSION_ID;
            default: reg_read = 16'h0000;
        endcase
    endfunction

    // handshake readies straight from state
    assign s_axi_awready = !st.awg && !st.bv;
    assign s_axi_wready = !st.wg && !st.bv;
    assign s_axi_arready = !st.rv;
    assign s_axi_bvalid = st.bv;
    assign s_axi_bresp = st.br;
    assign s_axi_rvalid = st.rv;
    assign s_axi_rdata = st.rd;
    assign s_axi_rresp = st.rr;
    assign link_out.bit_clock = st.bclk;
    assign link_out.frame_sync = st.sync;
    assign link_out.tx_data = st.txb;
    assign crystal_drive_output = ~st.xl;

    // whole next-state computation
    always_comb begin
        next_st = st;
        due_d = 1'b0;
        due_c = 1'b0;
        wr_now = 1'b0;
        bsel = 1'b0;
        cal_start = 1'b0;
        wa = 7'h00;
        wbyte = 8'h00;
        w16 = {st.rxw[14:0], st.dl};
        rbyte = reg_read(st, {w16[6:1], 1'b0});
        codec_en = !st.pdn[DAC_POWER_DOWN_BIT] || !st.pdn[ADC_POWER_DOWN_BIT];

        // three-stage synchronisers, value accepted when stages two and three agree
        next_st.xs = {st.xs[1:0], crystal_clock_input};
        next_st.ds = {st.ds[1:0], link_rx_data};
        next_st.m1 = mode_select;
        next_st.m2 = st.m1;
        next_st.m3 = st.m2;
        if (st.xs[1] == st.xs[2]) begin
            next_st.xl = st.xs[2];
        end
        if (st.ds[1] == st.ds[2]) begin
            next_st.dl = st.ds[2];
        end
        if (st.m2 == st.m3) begin
            next_st.ml = st.m3;
        end
        xtick = !st.xl && next_st.xl;

        // mode pins caught once, at the first cycle out of reset
        if (!st.locked) begin
            next_st.locked = 1'b1; // [RULE_23]
            next_st.dsp = (st.ml == MODE_DSP);
        end

        // start-up: wait for crystal ticks, then run the divider
        if (st.dsp && !st.brun && xtick) begin
            next_st.seen = 5'(st.seen + 5'h01);
            if (st.seen == XTAL_PRESENT_TICKS) begin
                next_st.brun = 1'b1; // [RULE_02]
            end
        end
        // divider follows the select field, so a wrong crystal scales the rates
        dn = div_of(st.cfg1[XTAL_LSB+:2]); // [RULE_01] [RULE_04]
        half = 4'((dn + 4'h1) >> 1);
        nd = (4'(st.div + 4'h1) >= dn) ? 4'h0 : 4'(st.div + 4'h1);
        rise = st.brun && xtick && (nd == 4'h0);
        fall = st.brun && xtick && (nd == half);
        if (st.brun && xtick) begin
            next_st.div = nd;
            next_st.bclk = (nd < half);
        end
        if (st.brun && !st.srun) begin
            next_st.swait = 16'(st.swait + 16'h0001);
            if (st.swait == 16'(SYNC_START_CYCLES - 1)) begin
                next_st.srun = 1'b1; // [RULE_03]
            end
        end

        // frame timing: phase accumulator keeps the average rate exact
        case (st.rate[SRG_LSB+:2])
            SRG_8_7: begin
                inc = 32'(st.rate[13:0]) * DDS_MUL_8;
                mdl = DDS_MOD_7;
            end
            SRG_10_7: begin
                inc = 32'(st.rate[13:0]) * DDS_MUL_10;
                mdl = DDS_MOD_7;
            end
            default: begin
                inc = 32'(st.rate[13:0]);
                mdl = DDS_MOD_1;
            end
        endcase
        sum = st.acc + inc;
        if (st.srun && rise) begin
            if (codec_en) begin
                next_st.idle = 9'h000;
                // at most one bit of jitter against hundreds per frame
                if (sum >= mdl) begin
                    next_st.acc = sum - mdl; // [RULE_15] [RULE_16]
                    due_d = 1'b1;
                end else begin
                    next_st.acc = sum;
                end
            end else begin
                next_st.acc = 32'h0000_0000;
                due_d = (st.idle == IDLE_FRAME_LAST); // [RULE_13] [RULE_15]
                next_st.idle = due_d ? 9'h000 : 9'(st.idle + 9'h001);
            end
            // a data frame landing on the control slot wins; spacing stays put
            due_c = !due_d && st.pend && (st.since == CTRL_OFFSET_LAST); // [RULE_14]
            if (due_d) begin
                next_st.since = 9'h000;
                next_st.fcnt = 16'(st.fcnt + 16'h0001);
            end else if (st.since != SINCE_MAX) begin
                next_st.since = 9'(st.since + 9'h001);
            end
            if (due_d || due_c) begin
                next_st.sync = 1'b1; // [RULE_06]
                next_st.ctl = due_c;
                next_st.pend = 1'b0;
                next_st.txi = 5'h00;
                next_st.rxc = 5'h00;
                next_st.txw = due_c ? 16'h0000 : st.adc; // [RULE_09] [RULE_12]
                next_st.txb = 1'b0;
            end else begin
                next_st.sync = 1'b0;
                if (st.txi < WORD_BITS) begin
                    next_st.txb = st.txw[4'(WORD_MSB - st.txi)]; // [RULE_05] [RULE_07] [RULE_08]
                    next_st.txi = 5'(st.txi + 5'h01);
                end else begin
                    next_st.txb = 1'b0; // [RULE_13]
                end
            end
        end

        // receive on falling edges, skipping the sync bit itself
        if (st.srun && fall && st.txi != 5'h00 && st.rxc < WORD_BITS) begin
            next_st.rxw = w16; // [RULE_08] [RULE_05]
            next_st.rxc = 5'(st.rxc + 5'h01);
            // read byte must be ready before the low half goes out
            if (st.ctl && st.rxc == CTRL_HDR_LAST && w16[7]) begin
                next_st.txw[7:0] = w16[0] ? rbyte[15:8] : rbyte[7:0]; // [RULE_11] [RULE_12]
            end
            if (st.rxc == WORD_LAST) begin
                if (!st.ctl) begin
                    next_st.dac = {w16[15:1], 1'b0}; // [RULE_09]
                    next_st.pend = w16[0]; // [RULE_10]
                end else if (!w16[15]) begin
                    wr_now = 1'b1; // [RULE_11]
                    wa = {w16[14:9], 1'b0};
                    bsel = w16[8];
                    wbyte = w16[7:0];
                end
            end
        end

        // control register writes, one byte each
        if (wr_now) begin
            case (wa)
                REG_STAT: begin
                    if (bsel) begin
                        next_st.pdn = wbyte;
                        cal_start = st.pdn[ADC_POWER_DOWN_BIT] && !wbyte[ADC_POWER_DOWN_BIT]; // [RULE_22]
                    end
                end
                REG_RATE: begin
                    if (bsel) begin
                        next_st.rate = {wbyte, st.rate_lo}; // [RULE_17]
                    end else begin
                        next_st.rate_lo = wbyte; // [RULE_17]
                    end
                end
                REG_LEVEL: next_st.level = put_byte(st.level, bsel, wbyte);
                REG_CFG1: begin
                    next_st.cfg1 = put_byte(st.cfg1, bsel, wbyte);
                    next_st.cfg1[ADC_CALIBRATE_BIT] = st.cfg1[ADC_CALIBRATE_BIT];
                    cal_start = bsel && wbyte[ADC_CALIBRATE_BIT - 8]; // [RULE_22]
                end
                REG_CFG2: next_st.cfg2 = put_byte(st.cfg2, bsel, wbyte);
                REG_BANK_A: begin
                    if (st.cfg1[BNK_LSB+:2] == BANK_1) begin
                        next_st.b1_60 = put_byte(st.b1_60, bsel, wbyte); // [RULE_19]
                    end else if (st.cfg1[BNK_LSB+:2] == BANK_2) begin
                        next_st.b2_60 = put_byte(st.b2_60, bsel, wbyte);
                    end
                end
                REG_BANK_B: begin
                    if (st.cfg1[BNK_LSB+:2] == BANK_1) begin
                        next_st.b1_64 = put_byte(st.b1_64, bsel, wbyte);
                    end
                end
                default: begin
                end
            endcase
        end

        // calibration timer; a new start wins over completion
        if (st.cfg1[ADC_CALIBRATE_BIT]) begin
            if (st.calc <= 16'h0001) begin
                next_st.cfg1[ADC_CALIBRATE_BIT] = 1'b0; // [RULE_24]
            end else begin
                next_st.calc = 16'(st.calc - 16'h0001);
            end
        end
        if (cal_start) begin
            next_st.cfg1[ADC_CALIBRATE_BIT] = 1'b1; // [RULE_22] [RULE_24]
            next_st.calc = 16'(CAL_CYCLES);
        end

        // axi4-lite write: address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.awg = 1'b1;
            next_st.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.wg = 1'b1;
            next_st.wd = s_axi_wdata;
            next_st.ws = s_axi_wstrb;
        end
        if (st.awg && st.wg) begin
            next_st.awg = 1'b0;
            next_st.wg = 1'b0;
            next_st.bv = 1'b1;
            next_st.br = RESP_OKAY;
            case (st.awa)
                AXI_ADC: begin
                    if (st.ws[0]) begin
                        next_st.adc[7:0] = st.wd[7:0];
                    end
                    if (st.ws[1]) begin
                        next_st.adc[15:8] = st.wd[15:8];
                    end
                end
                AXI_DAC, AXI_STATUS, AXI_FCNT: begin
                end
                default: next_st.br = RESP_SLVERR;
            endcase
        end
        if (st.bv && s_axi_bready) begin
            next_st.bv = 1'b0;
        end
        // axi4-lite read
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rv = 1'b1;
            next_st.rr = RESP_OKAY;
            case (s_axi_araddr)
                AXI_ADC: next_st.rd = {16'h0000, st.adc};
                AXI_DAC: next_st.rd = {16'h0000, st.dac};
                AXI_STATUS: next_st.rd = {26'h0000000, st.pend, st.cfg1[ADC_CALIBRATE_BIT],
                                          codec_en, st.srun, st.brun, st.dsp};
                AXI_FCNT: next_st.rd = {16'h0000, st.fcnt};
                default: begin
                    next_st.rd = 32'h0000_0000;
                    next_st.rr = RESP_SLVERR;
                end
            endcase
        end
        if (st.rv && s_axi_rready) begin
            next_st.rv = 1'b0;
        end

        // reset: mode latch survives everything but power-on reset
        if (!aresetn || !por_n) begin
            next_st = '0;
            next_st.m1 = mode_select;
            next_st.m2 = st.m1;
            next_st.m3 = st.m2;
            next_st.ml = (st.m2 == st.m3) ? st.m3 : st.ml;
            next_st.locked = por_n && st.locked;
            next_st.dsp = por_n && st.dsp;
            next_st.txi = WORD_BITS;
            next_st.rxc = WORD_BITS;
            next_st.pdn = STAT_HI_RST;
            next_st.rate = RATE_RST;
            next_st.rate_lo = RATE_RST[7:0];
            next_st.level = LEVEL_RST;
            next_st.cfg1 = CFG1_RST;
            next_st.cfg2 = CFG2_RST;
            next_st.b1_64 = B1_64_RST;
            next_st.b2_60 = B2_60_RST;
        end
    end

    // single state register
    always_ff @(posedge aclk) begin
        st <= next_st;
    end
endmodule

// file: src/codec_dsp_pkg.sv
/*
 * Shared constants and types of the DSP-mode codec serial port.
 * Assumes a 125 MHz system clock and a 16-bit control register space.
 */
package codec_dsp_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int SYNC_START_US = 100;
    localparam int SYNC_START_CYC = SYNC_START_US * (CLK_HZ / 1_000_000);
    localparam int CAL_TIME_US = 100;
    localparam int CAL_CYC = CAL_TIME_US * (CLK_HZ / 1_000_000);
    localparam logic [4:0] XTAL_PRESENT_TICKS = 5'h10;
    localparam int BIT_RATE_HZ = 4_096_000;
    localparam logic [31:0] DDS_MOD_1 = 32'(BIT_RATE_HZ);
    localparam logic [31:0] DDS_MOD_7 = 32'(7 * BIT_RATE_HZ);
    localparam logic [31:0] DDS_MUL_8 = 32'h8;
    localparam logic [31:0] DDS_MUL_10 = 32'hA;
    localparam logic [8:0] IDLE_FRAME_LAST = 9'h1FF;
    localparam logic [8:0] CTRL_OFFSET_LAST = 9'h0FF;
    localparam logic [8:0] SINCE_MAX = 9'h1FF;
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam logic [4:0] WORD_MSB = 5'h0F;
    localparam logic [4:0] CTRL_HDR_LAST = 5'h07;
    localparam logic [4:0] WORD_LAST = 5'h0F;
    localparam logic [1:0] XTAL_12M = 2'h0;
    localparam logic [1:0] XTAL_32M = 2'h1;
    localparam logic [3:0] DIV_12M = 4'h3;
    localparam logic [3:0] DIV_24M = 4'h6;
    localparam logic [3:0] DIV_32M = 4'h8;
    localparam logic [1:0] SRG_8_7 = 2'h1;
    localparam logic [1:0] SRG_10_7 = 2'h2;
    localparam logic [1:0] MODE_DSP = 2'h0;
    localparam logic [1:0] BANK_1 = 2'h1;
    localparam logic [1:0] BANK_2 = 2'h2;
    localparam logic [6:0] REG_STAT = 7'h3E;
    localparam logic [6:0] REG_RATE = 7'h40;
    localparam logic [6:0] REG_LEVEL = 7'h46;
    localparam logic [6:0] REG_CFG1 = 7'h5C;
    localparam logic [6:0] REG_CFG2 = 7'h5E;
    localparam logic [6:0] REG_BANK_A = 7'h60;
    localparam logic [6:0] REG_BANK_B = 7'h64;
    localparam logic [6:0] REG_VERSION = 7'h7A;
    localparam logic [7:0] STAT_HI_RST = 8'hFF;
    localparam logic [15:0] RATE_RST = 16'h3E80;
    localparam logic [15:0] LEVEL_RST = 16'h8080;
    localparam logic [15:0] CFG1_RST = 16'h18C0;
    localparam logic [15:0] CFG2_RST = 16'h0018;
    localparam logic [15:0] B1_64_RST = 16'h0077;
    localparam logic [15:0] B2_60_RST = 16'h4000;
    localparam logic [15:0] VERSION_ID = 16'h0001; // arbitrary value
    localparam int DAC_POWER_DOWN_BIT = 3; // within the power-down byte
    localparam int ADC_POWER_DOWN_BIT = 2;
    localparam int ADC_CALIBRATE_BIT = 8;
    localparam int BNK_LSB = 13;
    localparam int XTAL_LSB = 10;
    localparam int SRG_LSB = 14;
    localparam logic [7:0] AXI_ADC = 8'h00;
    localparam logic [7:0] AXI_DAC = 8'h04;
    localparam logic [7:0] AXI_STATUS = 8'h08;
    localparam logic [7:0] AXI_FCNT = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic bit_clock;
        logic frame_sync;
        logic tx_data;
    } link_out_t;
endpackage

// file: sim/codec_dsp_serial_port_properties.sv
/* checker for the link pins and the axi read and write answers
   assumes: bound to codec_dsp_serial_port, everything on aclk */
`timescale 1ns/1ps
module codec_dsp_port_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire codec_dsp_pkg::link_out_t link_out,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    import codec_dsp_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !por_n);
    // link outputs move only with a bit clock rise; sync lasts one bit with data low
    a_sync_on_rise: assert property ($changed(link_out.frame_sync) |-> $rose(link_out.bit_clock))
        else $error("sync moved off a bit clock rise");
    a_tx_on_rise: assert property ($changed(link_out.tx_data) |-> $rose(link_out.bit_clock))
        else $error("data moved off a bit clock rise");
    a_sync_one_bit: assert property ($rose(link_out.bit_clock) && $past(link_out.frame_sync) |-> !link_out.frame_sync)
        else $error("sync longer than one bit");
    a_tx_quiet_sync: assert property (link_out.frame_sync |-> !link_out.tx_data)
        else $error("data high during sync bit");
    // answers stand until taken; a read answer comes the cycle after its address
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer open");
endmodule
bind codec_dsp_serial_port codec_dsp_port_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .por_n(por_n), .link_out(link_out), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata));

// file: sim/dsp_port_model.sv
/* far-side model of a dsp serial controller
   assumes: codec drives bit clock and sync, bench sets the outgoing word */
`timescale 1ns/1ps
module dsp_port_model (
    input wire logic bit_clock,
    input wire logic frame_sync,
    input wire logic tx_data,
    input wire logic [15:0] send_word,
    output logic rx_data,
    output logic [15:0] got_word,
    output logic [7:0] n_frames
);
    logic seen;
    logic [4:0] tx_left;
    logic [4:0] rx_left;
    logic [15:0] shift;
    initial begin
        rx_data = 1'b0;
        seen = 1'b0;
        tx_left = 5'h0;
        rx_left = 5'h0;
        n_frames = 8'h0;
        got_word = 16'h0;
    end
    // drive on rises, msb first; toggle outside a word so stale bits never match
    always @(posedge bit_clock) begin
        if (seen) tx_left = 5'h10;
        if (tx_left != 5'h0) begin
            tx_left = tx_left - 5'h1;
            rx_data <= send_word[tx_left[3:0]];
        end else begin
            rx_data <= ~rx_data;
        end
    end
    // sample on falls; a sync seen here arms both directions
    always @(negedge bit_clock) begin
        if (rx_left != 5'h0) begin
            shift = {shift[14:0], tx_data};
            rx_left = rx_left - 5'h1;
            if (rx_left == 5'h0) begin
                got_word <= shift;
                n_frames <= n_frames + 8'h1;
            end
        end
        if (frame_sync) rx_left = 5'h10;
        seen <= frame_sync;
    end
endmodule

// file: sim/codec_dsp_serial_port_test.sv
/* top bench: axi tasks, partner model, frame content and spacing checks
   assumes: package, design, model and checker compiled before */
`timescale 1ns/1ps
module codec_dsp_serial_port_test;
    import codec_dsp_pkg::*;
    localparam int FRAME_GAP = 256 * 6 * 80; // control frame offset in ns
    logic aclk, aresetn, por_n, xtal, rx, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] mode_select, bresp, rresp, r;
    logic [7:0] awaddr, araddr, n_frames;
    logic [31:0] wdata, rdata, d;
    logic [15:0] send_word, got_word;
    link_out_t link_out;
    int errors = 0, n_tests = 0;
    longint t0;
    codec_dsp_serial_port #(.SYNC_START_CYCLES(50), .CAL_CYCLES(20)) i_dut (.aclk(aclk),
        .aresetn(aresetn), .por_n(por_n), .crystal_clock_input(xtal), .mode_select(mode_select),
        .link_rx_data(rx), .link_out(link_out), .crystal_drive_output(), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    dsp_port_model i_dsp (.bit_clock(link_out.bit_clock), .frame_sync(link_out.frame_sync),
        .tx_data(link_out.tx_data), .send_word(send_word), .rx_data(rx), .got_word(got_word),
        .n_frames(n_frames));
    // crystal runs free at a tenth of the aclk rate, edges on aclk edges
    initial begin aclk = 1'b0; forever #4 aclk = ~aclk; end
    initial begin xtal = 1'b0; forever #40 xtal = ~xtal; end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // both channels offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // wait for a finished word; only the watchdog ends a hang
    task automatic wait_frame();
        logic [7:0] n;
        n = n_frames;
        while (n_frames == n) @(posedge aclk);
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        {aresetn, por_n, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {mode_select, awaddr, araddr, wdata} = 50'h0;
        send_word = 16'h1235; // control frame asked, codec off
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge aclk);
        axi_wr(AXI_ADC, 32'h0000A5C3);
        chk(32'(r), 32'(RESP_OKAY));
        axi_rd(8'h10);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        wait_frame();
        t0 = $time;
        send_word <= 16'hDD00; // read high byte of 0x5C
        chk(32'(got_word), 32'h0000A5C3);
        repeat (8) @(posedge aclk);
        axi_rd(AXI_DAC);
        chk(d, 32'h00001234);
        wait_frame();
        chk(32'($time - t0), FRAME_GAP);
        chk(32'(got_word), 32'h00000018);
        axi_rd(AXI_FCNT);
        chk(d, 32'h00000001);
        axi_rd(AXI_STATUS);
        chk(d, 32'h00000007);
        complete_run();
    end
    // hang guard: the sequence needs about 48000 cycles
    initial begin
        repeat (60000) @(posedge aclk);
        errors++;
        complete_run();
    end
endmodule
